/* hw/instr_length_operand_decoder.sv */
// Purpose: collects an instruction's bytes and reports length, operand form and field usage
// Assumes: fetch presents one byte per byte_valid_in; regs_in holds the active bank
// Notes: results are registered and appear two cycles after the last byte is taken
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - register field selects one of four registers
// - relative displacement spans -64 to +63
// - indexed memory reference results go to register zero
// - indexed unconditional branch/call index register three
// - indexed unconditional branch/call never auto-step
// - other indexed forms: plain, increment or decrement
// - relative and absolute forms carry indirect flag
// - register-zero arithmetic and moves are one byte
// - conditional relative branches and calls two bytes
// - conditional absolute branches are three bytes
// - increment-register relative branch, two bytes, step first
// - decrement-register absolute branch, three bytes, step first
// - indexed unconditional absolute branch three bytes
// - zero-page relative unconditional branch two bytes
// - enabling return one byte, clears inhibit when taken
// - status clear/preset/test two bytes, mask second
// - status load/store are one byte
// - halt is one byte, enters wait state
// - immediate mask test is two bytes
// - relative addresses wrap modulo 8K within page
// - index step completes before displacement addition
// - index values unsigned 0 to 255, wrapping
module instr_length_operand_decoder
	import decode_pkg::*;
#(
	parameter int TABLE_ENTRIES = 256
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic byte_valid_in,
	input wire logic [7:0] byte_in,
	input wire logic [14:0] pc_in,
	input wire logic [3:0][7:0] regs_in,
	input wire logic cond_met_in,
	input wire logic resume_in,
	input wire logic table_wr_in,
	input wire logic [7:0] table_addr_in,
	input wire instr_class_e table_class_in,
	output logic decode_valid_out,
	output var instr_class_e class_out,
	output logic [1:0] length_out,
	output var operand_form_e form_out,
	output logic [1:0] reg_field_out,
	output logic [1:0] dest_reg_out,
	output logic [1:0] index_reg_out,
	output var index_mode_e index_mode_out,
	output logic indirect_out,
	output logic [6:0] displacement_out,
	output logic [14:0] target_addr_out,
	output logic [7:0] index_next_out,
	output logic [7:0] reg_next_out,
	output logic reg_write_out,
	output logic [7:0] immediate_out,
	output logic branch_take_out,
	output logic irq_inhibit_clear_out,
	output logic halt_out
);

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_OPND1 = 2'b01,
		ST_OPND2 = 2'b11,
		ST_DONE = 2'b10
	} state_e;

	state_e state;
	instr_class_e table_class;
	instr_class_e cls;
	logic [7:0] opcode;
	logic [7:0] byte2;
	logic [7:0] byte3;
	logic [1:0] len;
	logic [14:0] instr_addr;

	// decode results for the held instruction
	operand_form_e next_form;
	index_mode_e next_mode;
	logic [1:0] next_dest;
	logic [1:0] next_index_reg;
	logic next_indirect;
	logic [14:0] next_target;
	logic [7:0] next_index;
	logic [7:0] next_reg;
	logic next_reg_write;
	logic next_take;
	logic [7:0] idx_raw;
	logic [7:0] sel_reg;
	logic [12:0] disp_ext;
	logic [14:0] abs_base;

	opcode_class_table #(
		.ENTRIES(TABLE_ENTRIES)
	) u_table (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.wr_in(table_wr_in),
		.wr_addr_in(table_addr_in),
		.wr_class_in(table_class_in),
		.rd_addr_in(byte_in),
		.rd_class_out(table_class)
	);

	// byte collection; no bytes are taken while halted or while results are formed
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state <= ST_IDLE;
		end else begin
			case (state)
				ST_IDLE: begin
					if (byte_valid_in && !halt_out) begin
						state <= (instr_length(table_class) == LEN_ONE) ? ST_DONE : ST_OPND1;
					end
				end
				ST_OPND1: begin
					if (byte_valid_in) begin
						state <= (len == LEN_TWO) ? ST_DONE : ST_OPND2;
					end
				end
				ST_OPND2: begin
					if (byte_valid_in) begin
						state <= ST_DONE;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			opcode <= BYTE_RESET;
			cls <= CLS_INVALID;
			len <= LEN_ONE;
			instr_addr <= ADDR_RESET;
			byte2 <= BYTE_RESET;
			byte3 <= BYTE_RESET;
		end else if (state == ST_IDLE && byte_valid_in && !halt_out) begin
			opcode <= byte_in;
			cls <= table_class;
			len <= instr_length(table_class);
			instr_addr <= pc_in;
			byte2 <= BYTE_RESET;
			byte3 <= BYTE_RESET;
		end else if (state == ST_OPND1 && byte_valid_in) begin
			byte2 <= byte_in;
		end else if (state == ST_OPND2 && byte_valid_in) begin
			byte3 <= byte_in;
		end
	end

	always_comb begin
		disp_ext = {{(PAGE_BITS - 7){byte2[DISP_MSB]}}, byte2[DISP_MSB:0]};
		sel_reg = regs_in[opcode[1:0]];
		next_dest = opcode[1:0];
		next_index_reg = opcode[1:0];
		next_mode = IDX_NONE;
		next_form = FORM_NONE;
		next_indirect = 1'b0;
		next_target = ADDR_RESET;
		next_reg = sel_reg;
		next_reg_write = 1'b0;
		next_take = 1'b0;
		abs_base = {instr_addr[14:13], byte2[ABS_HI_MSB:0], byte3};
		case (cls)
			CLS_REG_ZERO: begin
				next_form = FORM_REG_ZERO;
			end
			CLS_IMMEDIATE, CLS_STATUS_MASK, CLS_MASK_TEST_IMM, CLS_IO_EXTENDED: begin
				next_form = FORM_IMMEDIATE;
			end
			CLS_REL_MEM, CLS_COND_REL_BRANCH, CLS_INC_REG_REL_BRANCH,
			CLS_DEC_REG_REL_BRANCH: begin
				next_form = FORM_RELATIVE;
				next_indirect = byte2[INDIRECT_BIT];
				// wrap inside the page; the page bits never change
				next_target = {instr_addr[14:13], instr_addr[12:0] + disp_ext};
			end
			CLS_ZERO_PAGE_REL: begin
				next_form = FORM_RELATIVE;
				next_indirect = byte2[INDIRECT_BIT];
				next_target = {2'b00, disp_ext};
			end
			CLS_ABS_MEM: begin
				next_form = FORM_ABSOLUTE;
				next_indirect = byte2[INDIRECT_BIT];
				next_mode = index_mode_e'(byte2[IDX_CTL_LO +: 2]);
				next_target = abs_base;
				if (next_mode != IDX_NONE) begin
					next_form = FORM_INDEXED;
					next_dest = RESULT_REG;
				end
			end
			CLS_COND_ABS_BRANCH, CLS_INC_REG_ABS_BRANCH, CLS_DEC_REG_ABS_BRANCH: begin
				next_form = FORM_ABSOLUTE;
				next_indirect = byte2[INDIRECT_BIT];
				next_target = {byte2[BR_HI_MSB:0], byte3};
			end
			CLS_INDEXED_UNCOND: begin
				next_form = FORM_INDEXED;
				next_indirect = byte2[INDIRECT_BIT];
				next_index_reg = UNCOND_INDEX_REG;
				next_mode = IDX_PLAIN;
				next_target = {byte2[BR_HI_MSB:0], byte3};
			end
			default: begin
				next_form = FORM_NONE;
			end
		endcase
		idx_raw = regs_in[next_index_reg];
		// step first, then add; 8-bit arithmetic wraps 255 to 0
		case (next_mode)
			IDX_INC: next_index = idx_raw + 8'h01;
			IDX_DEC: next_index = idx_raw - 8'h01;
			default: next_index = idx_raw;
		endcase
		if (next_mode != IDX_NONE) begin
			// indexing cannot carry into the page bits
			next_target = {next_target[14:13], next_target[12:0] + {5'b00000, next_index}};
		end
		case (cls)
			CLS_INC_REG_REL_BRANCH, CLS_INC_REG_ABS_BRANCH: begin
				next_reg = sel_reg + 8'h01;
				next_reg_write = 1'b1;
				next_take = next_reg != BYTE_RESET;
			end
			CLS_DEC_REG_REL_BRANCH, CLS_DEC_REG_ABS_BRANCH: begin
				next_reg = sel_reg - 8'h01;
				next_reg_write = 1'b1;
				next_take = next_reg != BYTE_RESET;
			end
			CLS_INDEXED_UNCOND, CLS_ZERO_PAGE_REL: begin
				next_take = 1'b1;
			end
			CLS_COND_REL_BRANCH, CLS_COND_ABS_BRANCH, CLS_RETURN,
			CLS_RETURN_ENABLE_IRQ: begin
				next_take = cond_met_in;
			end
			default: begin
				next_take = 1'b0;
			end
		endcase
	end

	// results are formed in ST_DONE and held until the next instruction completes, except the valid, register-write and inhibit-clear one-cycle pulses
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			decode_valid_out <= 1'b0;
			class_out <= CLS_INVALID;
			length_out <= LEN_ONE;
			form_out <= FORM_NONE;
			reg_field_out <= RESULT_REG;
			dest_reg_out <= RESULT_REG;
			index_reg_out <= RESULT_REG;
			index_mode_out <= IDX_NONE;
			indirect_out <= 1'b0;
			displacement_out <= 7'h00;
			target_addr_out <= ADDR_RESET;
			index_next_out <= BYTE_RESET;
			reg_next_out <= BYTE_RESET;
			reg_write_out <= 1'b0;
			immediate_out <= BYTE_RESET;
			branch_take_out <= 1'b0;
			irq_inhibit_clear_out <= 1'b0;
		end else begin
			decode_valid_out <= state == ST_DONE;
			irq_inhibit_clear_out <= 1'b0;
			reg_write_out <= 1'b0;
			if (state == ST_DONE) begin
				class_out <= cls;
				length_out <= len;
				form_out <= next_form;
				reg_field_out <= opcode[1:0];
				dest_reg_out <= next_dest;
				index_reg_out <= next_index_reg;
				index_mode_out <= next_mode;
				indirect_out <= next_indirect;
				displacement_out <= byte2[DISP_MSB:0];
				target_addr_out <= next_target;
				index_next_out <= next_index;
				reg_next_out <= next_reg;
				reg_write_out <= next_reg_write;
				immediate_out <= byte2;
				branch_take_out <= next_take;
				irq_inhibit_clear_out <= (cls == CLS_RETURN_ENABLE_IRQ) && cond_met_in;
			end
		end
	end

	// wait state; a halt finishing together with resume still halts
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			halt_out <= 1'b0;
		end else if (state == ST_DONE && cls == CLS_HALT) begin
			halt_out <= 1'b1;
		end else if (resume_in) begin
			halt_out <= 1'b0;
		end
	end

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);

	sequence s_start_one;
		state == ST_IDLE && byte_valid_in && !halt_out && instr_length(table_class) == LEN_ONE;
	endsequence
	sequence s_start_two;
		state == ST_IDLE && byte_valid_in && !halt_out && instr_length(table_class) == LEN_TWO;
	endsequence
	sequence s_second_byte;
		state == ST_OPND1 && byte_valid_in;
	endsequence

	chk_one_byte_done: assert property (s_start_one |=> ##1 decode_valid_out && length_out == LEN_ONE)
		else $error("one byte instruction not reported two cycles later");
	chk_two_byte_done: assert property (s_start_two ##1 s_second_byte |=> ##1
		decode_valid_out && length_out == LEN_TWO && immediate_out == $past(byte_in, 2))
		else $error("two byte instruction length or second byte wrong");
	chk_rel_in_page: assert property (decode_valid_out && form_out == FORM_RELATIVE
		&& class_out != CLS_ZERO_PAGE_REL |-> target_addr_out[14:13] == $past(instr_addr[14:13]))
		else $error("relative target left its page");
	chk_indexed_dest: assert property (decode_valid_out && class_out == CLS_ABS_MEM
		&& index_mode_out != IDX_NONE |-> dest_reg_out == RESULT_REG)
		else $error("indexed memory result not sent to register zero");
	chk_uncond_index: assert property (decode_valid_out && class_out == CLS_INDEXED_UNCOND
		|-> index_reg_out == UNCOND_INDEX_REG && index_mode_out == IDX_PLAIN)
		else $error("indexed unconditional branch uses wrong index");
	chk_inc_branch: assert property (state == ST_DONE && (cls == CLS_INC_REG_REL_BRANCH)
		|=> reg_next_out == 8'($past(sel_reg) + 8'h01) && branch_take_out == (reg_next_out != 8'h00))
		else $error("increment branch step or decision wrong");
	chk_dec_branch: assert property (state == ST_DONE && (cls == CLS_DEC_REG_ABS_BRANCH)
		|=> reg_next_out == 8'($past(sel_reg) - 8'h01) && branch_take_out == (reg_next_out != 8'h00))
		else $error("decrement branch step or decision wrong");
	chk_index_step: assert property (state == ST_DONE && next_mode == IDX_INC
		|=> index_next_out == 8'($past(idx_raw) + 8'h01))
		else $error("index increment did not wrap correctly");
	chk_irq_clear: assert property (irq_inhibit_clear_out
		|-> class_out == CLS_RETURN_ENABLE_IRQ && branch_take_out && decode_valid_out)
		else $error("interrupt inhibit cleared without a taken enabling return");
	chk_halt_hold: assert property (decode_valid_out && class_out == CLS_HALT && !resume_in
		|=> halt_out [*2])
		else $error("halt did not hold the wait state");

endmodule : instr_length_operand_decoder
`default_nettype wire

/* pkg/decode_pkg.sv */
// Purpose: shared types and constants for the instruction length and operand decoder
// Assumes: 8-bit opcodes, 15-bit addresses split into four 8K pages
// Notes: operand byte field positions are fixed here and used by the decoder only
package decode_pkg;

	typedef enum logic [4:0] {
		CLS_INVALID = 5'h00,
		CLS_REG_ZERO = 5'h01,
		CLS_IMMEDIATE = 5'h02,
		CLS_REL_MEM = 5'h03,
		CLS_ABS_MEM = 5'h04,
		CLS_COND_REL_BRANCH = 5'h05,
		CLS_COND_ABS_BRANCH = 5'h06,
		CLS_INC_REG_REL_BRANCH = 5'h07,
		CLS_INC_REG_ABS_BRANCH = 5'h08,
		CLS_DEC_REG_REL_BRANCH = 5'h09,
		CLS_DEC_REG_ABS_BRANCH = 5'h0a,
		CLS_INDEXED_UNCOND = 5'h0b,
		CLS_ZERO_PAGE_REL = 5'h0c,
		CLS_RETURN = 5'h0d,
		CLS_RETURN_ENABLE_IRQ = 5'h0e,
		CLS_STATUS_MASK = 5'h0f,
		CLS_STATUS_MOVE = 5'h10,
		CLS_HALT = 5'h11,
		CLS_MASK_TEST_IMM = 5'h12,
		CLS_REG_ONLY = 5'h13,
		CLS_IO_EXTENDED = 5'h14
	} instr_class_e;

	typedef enum logic [2:0] {
		FORM_NONE = 3'h0,
		FORM_REG_ZERO = 3'h1,
		FORM_IMMEDIATE = 3'h2,
		FORM_RELATIVE = 3'h3,
		FORM_ABSOLUTE = 3'h4,
		FORM_INDEXED = 3'h5
	} operand_form_e;

	typedef enum logic [1:0] {
		IDX_NONE = 2'h0,
		IDX_INC = 2'h1,
		IDX_DEC = 2'h2,
		IDX_PLAIN = 2'h3
	} index_mode_e;

	localparam logic [1:0] LEN_ONE = 2'h1;
	localparam logic [1:0] LEN_TWO = 2'h2;
	localparam logic [1:0] LEN_THREE = 2'h3;
	localparam logic [1:0] RESULT_REG = 2'h0;
	localparam logic [1:0] UNCOND_INDEX_REG = 2'h3;
	localparam int INDIRECT_BIT = 7;
	localparam int DISP_MSB = 6;
	localparam int IDX_CTL_LO = 5;
	localparam int ABS_HI_MSB = 4;
	localparam int BR_HI_MSB = 6;
	localparam int PAGE_BITS = 13;
	localparam int ADDR_BITS = 15;
	localparam int DISP_MIN = -64;
	localparam int DISP_MAX = 63;
	localparam logic [7:0] INDEX_MAX = 8'hff;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [14:0] ADDR_RESET = 15'h0000;

	function automatic logic [1:0] instr_length(input instr_class_e cls);
		logic [1:0] len;
		len = LEN_ONE;
		case (cls)
			CLS_IMMEDIATE, CLS_REL_MEM, CLS_COND_REL_BRANCH, CLS_INC_REG_REL_BRANCH,
			CLS_DEC_REG_REL_BRANCH, CLS_ZERO_PAGE_REL, CLS_STATUS_MASK,
			CLS_MASK_TEST_IMM, CLS_IO_EXTENDED: len = LEN_TWO;
			CLS_ABS_MEM, CLS_COND_ABS_BRANCH, CLS_INC_REG_ABS_BRANCH,
			CLS_DEC_REG_ABS_BRANCH, CLS_INDEXED_UNCOND: len = LEN_THREE;
			default: len = LEN_ONE;
		endcase
		return len;
	endfunction : instr_length

endpackage : decode_pkg

/* hw/opcode_class_table.sv */
// Purpose: first-byte opcode to instruction class lookup, loaded from outside
// Assumes: writes come from the same clock domain as the decoder
// Notes: every entry reads as the invalid class until written
`timescale 1ns/1ps
`default_nettype none
module opcode_class_table
	import decode_pkg::*;
#(
	parameter int ENTRIES = 256
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic wr_in,
	input wire logic [7:0] wr_addr_in,
	input wire instr_class_e wr_class_in,
	input wire logic [7:0] rd_addr_in,
	output instr_class_e rd_class_out
);

	instr_class_e entry [ENTRIES];

	// one flip-flop word per opcode; the encoding is not baked into the decoder
	for (genvar i = 0; i < ENTRIES; i++) begin : g_entry
		always_ff @(posedge clk_in or negedge rst_n_in) begin
			if (!rst_n_in) begin
				entry[i] <= CLS_INVALID;
			end else if (wr_in && wr_addr_in == 8'(i)) begin
				entry[i] <= wr_class_in;
			end
		end
	end

	assign rd_class_out = entry[rd_addr_in];

endmodule : opcode_class_table
`default_nettype wire

/* testbench/fetch_model.sv */
// Purpose: fetch-side model that hands instruction bytes to the decoder
// Assumes: a one-cycle go pulse, sampled on the rising edge, starts a transfer
// Notes: slow mode leaves an idle cycle between bytes; idle data is scrambled
`timescale 1ns/1ps
`default_nettype none
module fetch_model (
	input wire logic clk_in,
	input wire logic go_in,
	input wire logic [23:0] bytes_in,
	input wire logic [1:0] count_in,
	input wire logic slow_in,
	output logic byte_valid_out,
	output logic [7:0] byte_out
);
	initial begin
		byte_valid_out = 1'b0;
		byte_out = 8'h5a;
		forever begin
			@(posedge clk_in);
			if (go_in) begin
				for (int i = 0; i < int'(count_in); i++) begin
					if (slow_in && i > 0) begin
						@(negedge clk_in);
						byte_valid_out = 1'b0;
						// inverted so a stale byte is never mistaken for a fresh one
						byte_out = ~byte_out;
					end
					@(negedge clk_in);
					byte_valid_out = 1'b1;
					byte_out = bytes_in[8*i +: 8];
				end
				@(negedge clk_in);
				byte_valid_out = 1'b0;
				byte_out = ~byte_out;
			end
		end
	end
endmodule : fetch_model
`default_nettype wire

/* testbench/test_instr_length_operand_decoder.sv */
// Purpose: self-checking bench for the instruction length and operand decoder
// Assumes: class table loaded as opcode mod 21, opcode 8'hff left unloaded
// Notes: random stream with fixed seed plus wrap and boundary corners
`timescale 1ns/1ps
`default_nettype none
module test_instr_length_operand_decoder
	import decode_pkg::*;
;
	localparam int LIMIT = 20000;
	logic clk_in, rst_n_in, byte_valid_in, cond_met_in, resume_in, table_wr_in;
	logic [7:0] byte_in, table_addr_in, index_next_out, reg_next_out, immediate_out;
	logic [14:0] pc_in, target_addr_out;
	logic [3:0][7:0] regs_in, regs;
	instr_class_e table_class_in, class_out;
	operand_form_e form_out;
	index_mode_e index_mode_out;
	logic [1:0] length_out, reg_field_out, dest_reg_out, index_reg_out, count;
	logic [6:0] displacement_out;
	logic decode_valid_out, indirect_out, reg_write_out, branch_take_out;
	logic irq_inhibit_clear_out, halt_out, go, slow_sel, cond;
	logic [23:0] bytes;
	int fail_count, total_checks, cycles;

	instr_length_operand_decoder instr_length_operand_decoder_i (.clk_in, .rst_n_in,
		.byte_valid_in, .byte_in, .pc_in, .regs_in, .cond_met_in, .resume_in, .table_wr_in,
		.table_addr_in, .table_class_in, .decode_valid_out, .class_out, .length_out,
		.form_out, .reg_field_out, .dest_reg_out, .index_reg_out, .index_mode_out,
		.indirect_out, .displacement_out, .target_addr_out, .index_next_out, .reg_next_out,
		.reg_write_out, .immediate_out, .branch_take_out, .irq_inhibit_clear_out, .halt_out);
	fetch_model fetch_model_i (.clk_in, .go_in(go), .bytes_in(bytes), .count_in(count),
		.slow_in(slow_sel), .byte_valid_out(byte_valid_in), .byte_out(byte_in));

	initial begin
		clk_in = 1'b0;
		forever #2 clk_in = ~clk_in;
	end

	always @(posedge clk_in) begin
		cycles++;
		if (cycles == LIMIT) begin
			fail_count++;
			stop_test();
		end
	end

	function automatic instr_class_e exp_class(input logic [7:0] op);
		return (op == 8'hff) ? CLS_INVALID : instr_class_e'(5'(op % 8'd21));
	endfunction : exp_class

	function automatic logic [1:0] exp_len(input instr_class_e c);
		case (c)
			CLS_ABS_MEM, CLS_COND_ABS_BRANCH, CLS_INC_REG_ABS_BRANCH, CLS_DEC_REG_ABS_BRANCH,
			CLS_INDEXED_UNCOND: return 2'h3;
			CLS_IMMEDIATE, CLS_REL_MEM, CLS_COND_REL_BRANCH, CLS_INC_REG_REL_BRANCH,
			CLS_DEC_REG_REL_BRANCH, CLS_ZERO_PAGE_REL, CLS_STATUS_MASK, CLS_MASK_TEST_IMM,
			CLS_IO_EXTENDED: return 2'h2;
			default: return 2'h1;
		endcase
	endfunction : exp_len

	// operand form from the class; absolute memory turns indexed when the index control is set
	function automatic operand_form_e exp_form(input instr_class_e c, input logic [1:0] ctl);
		case (c)
			CLS_REG_ZERO: return FORM_REG_ZERO;
			CLS_IMMEDIATE, CLS_STATUS_MASK, CLS_MASK_TEST_IMM,
			CLS_IO_EXTENDED: return FORM_IMMEDIATE;
			CLS_REL_MEM, CLS_COND_REL_BRANCH, CLS_INC_REG_REL_BRANCH, CLS_DEC_REG_REL_BRANCH,
			CLS_ZERO_PAGE_REL: return FORM_RELATIVE;
			CLS_ABS_MEM: return (ctl == 2'h0) ? FORM_ABSOLUTE : FORM_INDEXED;
			CLS_COND_ABS_BRANCH, CLS_INC_REG_ABS_BRANCH,
			CLS_DEC_REG_ABS_BRANCH: return FORM_ABSOLUTE;
			CLS_INDEXED_UNCOND: return FORM_INDEXED;
			default: return FORM_NONE;
		endcase
	endfunction : exp_form

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	task automatic stop_test();
		$display("checks=%0d mismatches=%0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : stop_test

	task automatic wait_valid(output logic seen);
		seen = 1'b0;
		for (int i = 0; i < 12 && !seen; i++) begin
			@(negedge clk_in);
			seen = (decode_valid_out === 1'b1);
		end
	endtask : wait_valid

	task automatic check_fields(input logic [7:0] op, b2, b3, input logic [14:0] pc,
		input instr_class_e cls);
		logic [12:0] off;
		logic [7:0] idx;
		index_mode_e mode;
		mode = index_mode_e'(b2[6:5]);
		idx = regs[op[1:0]] + ((mode == IDX_INC) ? 8'h01 : 8'h00) - ((mode == IDX_DEC) ? 8'h01 : 8'h00);
		check(class_out, cls);
		check(length_out, exp_len(cls));
		check(reg_field_out, op[1:0]);
		check(form_out, exp_form(cls, b2[6:5]));
		if (exp_len(cls) > 2'h1) check(immediate_out, b2);
		if (cls inside {CLS_REL_MEM, CLS_COND_REL_BRANCH, CLS_INC_REG_REL_BRANCH,
			CLS_DEC_REG_REL_BRANCH}) begin
			off = pc[12:0] + {{6{b2[6]}}, b2[6:0]};
			check(displacement_out, b2[6:0]);
			check(target_addr_out, {pc[14:13], off});
		end
		if (cls == CLS_ZERO_PAGE_REL) check(target_addr_out, {2'b00, {6{b2[6]}}, b2[6:0]});
		if (cls inside {CLS_COND_REL_BRANCH, CLS_COND_ABS_BRANCH, CLS_RETURN, CLS_RETURN_ENABLE_IRQ})
			check(branch_take_out, cond);
		if (cls inside {CLS_INDEXED_UNCOND, CLS_ZERO_PAGE_REL})
			check(branch_take_out, 1'b1);
		if (cls inside {CLS_COND_ABS_BRANCH, CLS_INC_REG_ABS_BRANCH, CLS_DEC_REG_ABS_BRANCH})
			check(target_addr_out, {b2[6:0], b3});
		if (cls inside {CLS_REL_MEM, CLS_ABS_MEM, CLS_COND_REL_BRANCH, CLS_COND_ABS_BRANCH})
			check(indirect_out, b2[7]);
		if (cls == CLS_ABS_MEM) begin
			off = {b2[4:0], b3} + ((mode == IDX_NONE) ? 13'h0000 : {5'h00, idx});
			check(index_mode_out, mode);
			check(target_addr_out, {pc[14:13], off});
			if (mode != IDX_NONE) begin
				check(dest_reg_out, 2'h0);
				check(index_reg_out, op[1:0]);
				check(index_next_out, idx);
			end
		end
		if (cls == CLS_INDEXED_UNCOND) begin
			check(index_reg_out, 2'h3);
			check(index_next_out, regs[3]);
			check(index_mode_out == IDX_INC || index_mode_out == IDX_DEC, 1'b0);
		end
		if (cls inside {CLS_INC_REG_REL_BRANCH, CLS_INC_REG_ABS_BRANCH, CLS_DEC_REG_REL_BRANCH,
			CLS_DEC_REG_ABS_BRANCH}) begin
			// step first, then test the stepped value against zero
			idx = (cls inside {CLS_INC_REG_REL_BRANCH, CLS_INC_REG_ABS_BRANCH}) ?
				regs[op[1:0]] + 8'h01 : regs[op[1:0]] - 8'h01;
			check(reg_next_out, idx);
			check(branch_take_out, idx != 8'h00);
			check(reg_write_out, 1'b1);
		end else begin
			check(reg_write_out, 1'b0);
		end
		if (cls == CLS_RETURN) check(irq_inhibit_clear_out, 1'b0);
		if (cls == CLS_RETURN_ENABLE_IRQ)
			check(irq_inhibit_clear_out, cond);
	endtask : check_fields

	task automatic halt_seq();
		logic seen;
		@(negedge clk_in);
		check(halt_out, 1'b1);
		bytes = 24'h000001;
		count = 2'h1;
		go = 1'b1;
		@(negedge clk_in);
		go = 1'b0;
		wait_valid(seen);
		check(seen, 1'b0);
		resume_in = 1'b1;
		@(negedge clk_in);
		resume_in = 1'b0;
		@(negedge clk_in);
		check(halt_out, 1'b0);
	endtask : halt_seq

	task automatic run(input logic [7:0] op, b2, b3, input logic [14:0] pc, input logic slow);
		instr_class_e cls;
		logic seen;
		cls = exp_class(op);
		pc_in = pc;
		regs_in = regs;
		cond_met_in = cond;
		bytes = {b3, b2, op};
		count = exp_len(cls);
		slow_sel = slow;
		go = 1'b1;
		@(negedge clk_in);
		go = 1'b0;
		wait_valid(seen);
		check(seen, 1'b1);
		if (seen) check_fields(op, b2, b3, pc, cls);
		if (cls == CLS_HALT) halt_seq();
	endtask : run

	initial begin
		{rst_n_in, cond_met_in, resume_in, table_wr_in, go, slow_sel, cond} = '0;
		{table_addr_in, pc_in, regs_in, regs, bytes, count} = '0;
		table_class_in = CLS_INVALID;
		void'($urandom(32'hd6de5a0a));
		repeat (20) @(negedge clk_in);
		rst_n_in = 1'b1;
		for (int i = 0; i < 255; i++) begin
			@(negedge clk_in);
			table_wr_in = 1'b1;
			table_addr_in = 8'(i);
			table_class_in = exp_class(8'(i));
		end
		@(negedge clk_in);
		table_wr_in = 1'b0;
		// unloaded entry must read as invalid with a one-byte length
		run(8'hff, 8'h00, 8'h00, 15'h0000, 1'b0);
		$display("test done: unloaded entry");
		regs = {8'hff, 8'h01, 8'h00, 8'hff};
		cond = 1'b1;
		run(8'h03, 8'h10, 8'h00, 15'h1ffc, 1'b0);
		run(8'h03, 8'hc0, 8'h00, 15'h2001, 1'b1);
		run(8'h04, 8'h3f, 8'hff, 15'h4000, 1'b0);
		run(8'h19, 8'h40, 8'h05, 15'h6123, 1'b1);
		run(8'h07, 8'h3f, 8'h00, 15'h0100, 1'b0);
		run(8'h0a, 8'h12, 8'h34, 15'h0200, 1'b0);
		run(8'h0e, 8'h00, 8'h00, 15'h0300, 1'b0);
		run(8'h0d, 8'h00, 8'h00, 15'h0300, 1'b0);
		run(8'h0b, 8'h81, 8'h22, 15'h0400, 1'b1);
		run(8'h11, 8'h00, 8'h00, 15'h0500, 1'b0);
		$display("test done: corner forms");
		for (int n = 0; n < 300; n++) begin
			regs = $urandom;
			cond = 1'($urandom);
			run(8'($urandom), 8'($urandom), 8'($urandom), 15'($urandom), 1'($urandom));
		end
		$display("test done: random stream");
		stop_test();
	end
endmodule : test_instr_length_operand_decoder
`default_nettype wire
